// File: src/sw_glob_pkg.sv
package sw_glob_pkg;

	// printed offsets are not all multiples of four: each is a register index, byte address = 4 * index
	localparam logic [7:0] IDX_CTRL_A = 8'hAC;
	localparam logic [7:0] IDX_CTRL_B = 8'hAE;
	localparam logic [7:0] IDX_F1_LOW = 8'hB0;
	localparam logic [7:0] IDX_F1_MID = 8'hB2;
	localparam logic [7:0] IDX_F1_HIGH = 8'hB4;
	localparam logic [7:0] IDX_F2_LOW = 8'hB6;
	localparam logic [7:0] IDX_F2_MID = 8'hB8;
	localparam logic [7:0] IDX_F2_HIGH = 8'hBA;
	localparam int ADDR_W = 12;

	// control a fields
	localparam int QMAP_HI = 15;
	localparam int QMAP_LO = 14;
	localparam int DYN_FLUSH_BIT = 10;
	localparam int STAT_FLUSH_BIT = 9;
	localparam int TAIL_TAG_BIT = 8;
	localparam int PAUSE_LIM_HI = 7;
	localparam logic [15:0] CTRL_A_RW_MASK = 16'hC7FF;
	localparam logic [15:0] CTRL_A_RESET = 16'h8000;
	// control b fields
	localparam int INV_MASK_HI = 10;
	localparam int INV_MASK_LO = 8;
	localparam int TAG_INS_HI = 5;
	localparam logic [15:0] CTRL_B_RW_MASK = 16'h07FF;
	localparam logic [15:0] CTRL_B_RESET = 16'h0000;
	localparam logic [15:0] FILT_RESET = 16'h0000;

	// pause-off limit unit and its cycle count at 100 MHz, kept as a parameter for simulation
	localparam int PAUSE_UNIT_MS = 160;
	localparam int CLK_MHZ = 100;
	localparam int PAUSE_UNIT_CYC = PAUSE_UNIT_MS * 1000 * CLK_MHZ;

	typedef struct packed {
		logic [1:0] queue_map;
		logic static_flush;
		logic tail_tag_en;
		logic [2:0] invalid_vid_mask;
		logic [5:0] tag_insert_en;
		logic pause_off_limit_en;
		logic pause_off_expired;
		logic [47:0] filter_mac_one;
		logic [47:0] filter_mac_two;
	} switch_cfg_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

endpackage

// File: src/pause_limit_timer.sv
`timescale 1ns/1ps
`default_nettype none
// counts the forced pause-off window in 160 ms units; expired while the limit has run out
module pause_limit_timer #(
	parameter int UNIT_CYC = sw_glob_pkg::PAUSE_UNIT_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// control
	input wire logic [7:0] limit,
	input wire logic restart,
	// status
	output logic expired
);
	import sw_glob_pkg::*;

	logic [31:0] cyc;
	logic [7:0] units;
	logic [31:0] next_cyc;
	logic [7:0] next_units;
	logic next_expired;

	always_comb begin
		next_cyc = cyc;
		next_units = units;
		next_expired = expired;
		if (restart || limit == 8'h00) begin
			next_cyc = 32'h0;
			next_units = 8'h00;
			next_expired = 1'b0;
		end else if (!expired) begin
			if (cyc == 32'(UNIT_CYC - 1)) begin
				next_cyc = 32'h0;
				next_units = units + 8'h01;
				if (units + 8'h01 >= limit) begin
					next_expired = 1'b1;
				end
			end else begin
				next_cyc = cyc + 32'h1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cyc <= 32'h0;
			units <= 8'h00;
			expired <= 1'b0;
		end else begin
			cyc <= next_cyc;
			units <= next_units;
			expired <= next_expired;
		end
	end

endmodule
`default_nettype wire

// File: src/switch_global_ctrl_sa_filter_regs.sv
`timescale 1ns/1ps
`default_nettype none
module switch_global_ctrl_sa_filter_regs #(
	parameter int PAUSE_CYC = sw_glob_pkg::PAUSE_UNIT_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// apb slave
	input wire sw_glob_pkg::apb_req_t apb_req,
	output sw_glob_pkg::apb_rsp_t apb_rsp,
	// address table engine
	output logic dyn_flush_req,
	input wire logic dyn_flush_done,
	// configuration to the switch core
	output sw_glob_pkg::switch_cfg_t cfg
);
	import sw_glob_pkg::*;

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		byte_addr = ADDR_W'({idx, 2'b00});
	endfunction

	logic [15:0] ctrl_a;
	logic [15:0] ctrl_b;
	logic [15:0] filt [0:5];
	logic [31:0] rdata;
	logic slverr;
	logic [15:0] next_ctrl_a;
	logic [15:0] next_ctrl_b;
	logic [15:0] next_filt [0:5];
	logic [31:0] next_rdata;
	logic next_slverr;
	logic access;
	logic wr;
	logic pause_expired;
	logic pause_restart;
	logic [15:0] wd;
	logic [ADDR_W-1:0] a;

	assign access = apb_req.psel && apb_req.penable;
	assign wr = access && apb_req.pwrite;
	assign wd = apb_req.pwdata[15:0];
	assign a = apb_req.paddr;
	// writing control a restarts the pause-off window
	assign pause_restart = wr && a == byte_addr(IDX_CTRL_A);

	always_comb begin
		next_ctrl_a = ctrl_a;
		next_ctrl_b = ctrl_b;
		for (int i = 0; i < 6; i++) begin
			next_filt[i] = filt[i];
		end
		next_rdata = rdata;
		next_slverr = 1'b0;
		if (access && !apb_req.pwrite) begin
			next_rdata = 32'h0;
			if (a == byte_addr(IDX_CTRL_A)) begin
				next_rdata = {16'h0000, ctrl_a};
			end else if (a == byte_addr(IDX_CTRL_B)) begin
				next_rdata = {16'h0000, ctrl_b};
			end else if (a == byte_addr(IDX_F1_LOW)) begin
				next_rdata = {16'h0000, filt[0]};
			end else if (a == byte_addr(IDX_F1_MID)) begin
				next_rdata = {16'h0000, filt[1]};
			end else if (a == byte_addr(IDX_F1_HIGH)) begin
				next_rdata = {16'h0000, filt[2]};
			end else if (a == byte_addr(IDX_F2_LOW)) begin
				next_rdata = {16'h0000, filt[3]};
			end else if (a == byte_addr(IDX_F2_MID)) begin
				next_rdata = {16'h0000, filt[4]};
			end else if (a == byte_addr(IDX_F2_HIGH)) begin
				next_rdata = {16'h0000, filt[5]};
			end else begin
				next_slverr = 1'b1;
			end
		end
		if (wr) begin
			if (a == byte_addr(IDX_CTRL_A)) begin
				next_ctrl_a = wd & CTRL_A_RW_MASK;
				// a written one starts a flush; a running flush is not cancelled by writing zero
				next_ctrl_a[DYN_FLUSH_BIT] = wd[DYN_FLUSH_BIT] || ctrl_a[DYN_FLUSH_BIT];
			end else if (a == byte_addr(IDX_CTRL_B)) begin
				next_ctrl_b = wd & CTRL_B_RW_MASK;
			end else if (a == byte_addr(IDX_F1_LOW)) begin
				next_filt[0] = wd;
			end else if (a == byte_addr(IDX_F1_MID)) begin
				next_filt[1] = wd;
			end else if (a == byte_addr(IDX_F1_HIGH)) begin
				next_filt[2] = wd;
			end else if (a == byte_addr(IDX_F2_LOW)) begin
				next_filt[3] = wd;
			end else if (a == byte_addr(IDX_F2_MID)) begin
				next_filt[4] = wd;
			end else if (a == byte_addr(IDX_F2_HIGH)) begin
				next_filt[5] = wd;
			end else begin
				next_slverr = 1'b1;
			end
		end
		// self-clear on done, unless a new one is written in the same cycle
		if (dyn_flush_done && ctrl_a[DYN_FLUSH_BIT] && !(pause_restart && wd[DYN_FLUSH_BIT])) begin
			next_ctrl_a[DYN_FLUSH_BIT] = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_a <= CTRL_A_RESET;
			ctrl_b <= CTRL_B_RESET;
			for (int i = 0; i < 6; i++) begin
				filt[i] <= FILT_RESET;
			end
			rdata <= 32'h0;
			slverr <= 1'b0;
		end else begin
			ctrl_a <= next_ctrl_a;
			ctrl_b <= next_ctrl_b;
			for (int i = 0; i < 6; i++) begin
				filt[i] <= next_filt[i];
			end
			rdata <= next_rdata;
			slverr <= next_slverr;
		end
	end

	pause_limit_timer #(
		.UNIT_CYC(PAUSE_CYC)
	) u_pause (
		.sys_clk(sys_clk),
		.srst(srst),
		.limit(ctrl_a[PAUSE_LIM_HI:0]),
		.restart(pause_restart),
		.expired(pause_expired)
	);

	// zero-wait answer: data and error are driven combinationally from next_rdata and next_slverr and read by the master on the access edge
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.prdata = next_rdata;
	assign apb_rsp.pslverr = access && next_slverr;

	// learning must already be off on all ports; the engine relies on software for that
	assign dyn_flush_req = ctrl_a[DYN_FLUSH_BIT];
	assign cfg.queue_map = ctrl_a[QMAP_HI:QMAP_LO];
	assign cfg.static_flush = ctrl_a[STAT_FLUSH_BIT];
	assign cfg.tail_tag_en = ctrl_a[TAIL_TAG_BIT];
	assign cfg.pause_off_limit_en = ctrl_a[PAUSE_LIM_HI:0] != 8'h00;
	assign cfg.pause_off_expired = pause_expired;
	assign cfg.invalid_vid_mask = ctrl_b[INV_MASK_HI:INV_MASK_LO];
	assign cfg.tag_insert_en = ctrl_b[TAG_INS_HI:0];
	assign cfg.filter_mac_one = {filt[2], filt[1], filt[0]};
	assign cfg.filter_mac_two = {filt[5], filt[4], filt[3]};

endmodule
`default_nettype wire

// File: verification/sw_glob_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sw_glob_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// block ports
	input wire sw_glob_pkg::apb_req_t apb_req,
	input wire sw_glob_pkg::apb_rsp_t apb_rsp,
	input wire logic dyn_flush_req,
	input wire logic dyn_flush_done,
	input wire sw_glob_pkg::switch_cfg_t cfg
);
	import sw_glob_pkg::*;
	wire logic wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
	wire logic rd = apb_req.psel & apb_req.penable & !apb_req.pwrite;
	wire logic [11:0] ad = apb_req.paddr;
	wire logic [31:0] d = apb_req.pwdata;
	wire logic wr_a = wr && ad == 12'h2B0;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	chk_qmap_write: assert property (wr_a |=> cfg.queue_map == $past(d[15:14]))
		else $error("queue map differs from written code");
	chk_tail_static: assert property (wr_a |=> {cfg.static_flush, cfg.tail_tag_en} == $past(d[9:8]))
		else $error("static flush or tail tag differs from write");
	chk_flush_set: assert property (wr_a && d[10] |=> dyn_flush_req)
		else $error("flush request not raised");
	chk_flush_clear: assert property (dyn_flush_req && dyn_flush_done && !(wr_a && d[10]) |=> !dyn_flush_req)
		else $error("flush request not cleared on done");
	chk_flush_hold: assert property (dyn_flush_req && !dyn_flush_done |=> dyn_flush_req)
		else $error("flush request dropped early");
	chk_limit_enable: assert property (wr_a |=> cfg.pause_off_limit_en == ($past(d[7:0]) != 8'h00))
		else $error("pause limit enable wrong");
	chk_ctrl_b_write: assert property (wr && ad == 12'h2B8 |=>
		{cfg.invalid_vid_mask, cfg.tag_insert_en} == {$past(d[10:8]), $past(d[5:0])})
		else $error("control b fields differ from write");
	chk_reserved_read: assert property (rd &&
		(ad == 12'h2B0 && (apb_rsp.prdata & 32'hFFFF3800) != 32'h0 ||
		ad == 12'h2B8 && (apb_rsp.prdata & 32'hFFFFF800) != 32'h0) |-> 1'b0)
		else $error("reserved bits read non-zero");
	chk_filter_one: assert property (wr && ad == 12'h2C0 |=> cfg.filter_mac_one[15:0] == $past(d[15:0]))
		else $error("first filter low word differs");
	chk_filter_two: assert property (wr && ad == 12'h2E8 |=> cfg.filter_mac_two[47:32] == $past(d[15:0]))
		else $error("second filter high word differs");
endmodule
bind switch_global_ctrl_sa_filter_regs sw_glob_monitor mon (.sys_clk(sys_clk), .srst(srst), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .dyn_flush_req(dyn_flush_req), .dyn_flush_done(dyn_flush_done), .cfg(cfg));
`default_nettype wire

// File: verification/test_switch_global_ctrl_sa_filter_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_switch_global_ctrl_sa_filter_regs;
	import sw_glob_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic dyn_flush_done = 1'b0;
	apb_req_t apb_req = '0;
	apb_rsp_t apb_rsp;
	switch_cfg_t cfg;
	logic dyn_flush_req;
	int n_mismatch = 0;
	int tests_run = 0;
	always #5 sys_clk = ~sys_clk;
	switch_global_ctrl_sa_filter_regs #(.PAUSE_CYC(10)) DUT (.sys_clk(sys_clk), .srst(srst), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .dyn_flush_req(dyn_flush_req), .dyn_flush_done(dyn_flush_done), .cfg(cfg));
	function automatic logic [11:0] ba(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one apb transfer; upper write bits set to show they are ignored
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [31:0] exp, input logic ee);
		@(posedge sys_clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {16'hFFFF, d}};
		@(posedge sys_clk);
		apb_req.penable <= 1'b1;
		@(posedge sys_clk);
		while (apb_rsp.pready !== 1'b1) begin
			@(posedge sys_clk);
		end
		if (!w) chk("read data", 48'(exp), 48'(apb_rsp.prdata));
		chk("slave error", 48'(ee), 48'(apb_rsp.pslverr));
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask
	task automatic t_reset_vals;
		apb(1'b0, ba(IDX_CTRL_A), 16'h0000, 32'h00008000, 1'b0);
		apb(1'b0, ba(IDX_CTRL_B), 16'h0000, 32'h00000000, 1'b0);
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, ba(IDX_F1_LOW) + 12'(8 * i), 16'h0000, 32'h00000000, 1'b0);
		end
		chk("flush req", 48'h0, 48'(dyn_flush_req));
	endtask
	task automatic t_rw;
		apb(1'b1, ba(IDX_CTRL_A), 16'hFBFF, 32'h0, 1'b0);
		apb(1'b0, ba(IDX_CTRL_A), 16'h0000, 32'h0000C3FF, 1'b0);
		chk("static tail", 48'h3, 48'({cfg.static_flush, cfg.tail_tag_en}));
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, ba(IDX_CTRL_A), {2'(c), 14'h0000}, 32'h0, 1'b0);
			#1;
			chk("queue map", 48'(c), 48'(cfg.queue_map));
		end
		apb(1'b1, ba(IDX_CTRL_B), 16'hFFFF, 32'h0, 1'b0);
		apb(1'b0, ba(IDX_CTRL_B), 16'h0000, 32'h000007FF, 1'b0);
		apb(1'b1, ba(IDX_CTRL_B), 16'h0521, 32'h0, 1'b0);
		#1;
		chk("vid mask tag", 48'h161, 48'({cfg.invalid_vid_mask, cfg.tag_insert_en}));
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, ba(IDX_F1_LOW) + 12'(8 * i), 16'(16'h1111 * (i + 1)), 32'h0, 1'b0);
		end
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, ba(IDX_F1_LOW) + 12'(8 * i), 16'h0, 32'(16'h1111 * (i + 1)), 1'b0);
		end
		chk("filter one", 48'h333322221111, cfg.filter_mac_one);
		chk("filter two", 48'h666655554444, cfg.filter_mac_two);
	endtask
	task automatic t_flush;
		// learning is taken as already off on all ports here
		apb(1'b1, ba(IDX_CTRL_A), 16'h8400, 32'h0, 1'b0);
		#1;
		chk("flush req", 48'h1, 48'(dyn_flush_req));
		apb(1'b1, ba(IDX_CTRL_A), 16'h8000, 32'h0, 1'b0);
		apb(1'b0, ba(IDX_CTRL_A), 16'h0000, 32'h00008400, 1'b0);
		@(posedge sys_clk);
		dyn_flush_done <= 1'b1;
		@(posedge sys_clk);
		dyn_flush_done <= 1'b0;
		apb(1'b0, ba(IDX_CTRL_A), 16'h0000, 32'h00008000, 1'b0);
		chk("flush req", 48'h0, 48'(dyn_flush_req));
	endtask
	task automatic t_unmapped_pause;
		apb(1'b1, 12'h2B4, 16'hFFFF, 32'h0, 1'b1);
		apb(1'b0, 12'h2F0, 16'h0000, 32'h00000000, 1'b1);
		apb(1'b1, ba(IDX_CTRL_A), 16'h8002, 32'h0, 1'b0);
		repeat (10) @(posedge sys_clk);
		chk("limit en expired", 48'h2, 48'({cfg.pause_off_limit_en, cfg.pause_off_expired}));
		repeat (20) @(posedge sys_clk);
		chk("limit en expired", 48'h3, 48'({cfg.pause_off_limit_en, cfg.pause_off_expired}));
		apb(1'b1, ba(IDX_CTRL_A), 16'h8000, 32'h0, 1'b0);
		#1;
		chk("limit en", 48'h0, 48'(cfg.pause_off_limit_en));
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		t_reset_vals;
		t_rw;
		t_flush;
		t_unmapped_pause;
		srst <= 1'b1;
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		t_reset_vals;
		close_out;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_mismatch++;
		close_out;
	end
endmodule
`default_nettype wire
